// ==== hw/rhp_pkg.sv ====
package rhp_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int REF_CLK_HZ      = 40000000;
	localparam int REF_PERIOD_NS   = 25;
	// strobe on the run-state flip-flops, least width in ns
	localparam int STROBE_MIN_NS   = 45;
	localparam int STROBE_MAX_NS   = 55;
	// least width rounds up to whole cycles
	localparam int STROBE_MIN_CYC  =
		(STROBE_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	// machine cycle in ns and the run pulse width in ns
	localparam int MACH_CYCLE_NS   = 1600;
	localparam int RUN_PULSE_NS    = 1400;
	localparam int MACH_CYCLE_CYC  = MACH_CYCLE_NS / REF_PERIOD_NS;
	localparam int RUN_PULSE_CYC   = RUN_PULSE_NS / REF_PERIOD_NS;

	// ----------------------------------------
	// latch and run-state reset values
	// ----------------------------------------
	localparam logic LATCH_RST     = 1'h0;
	localparam logic RUN_STATE_RST = 1'h0;

	// ----------------------------------------
	// latch states
	// ----------------------------------------
	typedef enum logic [0:0] {
		RHP_OPEN   = 1'h0,
		RHP_CLOSED = 1'h1
	} rhp_latch_t;

endpackage

// ==== hw/rhp_run_halt.sv ====
`timescale 1ns/1ps
module rhp_run_halt
	import rhp_pkg::*;
(
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	input  wire logic i_ce,
	// front-panel contacts, asynchronous
	input  wire logic i_run_no,
	input  wire logic i_run_nc,
	input  wire logic i_halt_no,
	input  wire logic i_halt_nc,
	input  wire logic i_clear_req,
	// phase strobes, one-cycle pulses from the timing generator
	input  wire logic i_t1_strobe,
	input  wire logic i_t2_strobe,
	input  wire logic i_t5_end_strobe,
	input  wire logic i_phase_seven_s_strobe,
	// phase logic and lamps
	output logic      o_run_pulse,
	output logic      o_run_state_early,
	output logic      o_run_state_late,
	output logic      o_halt_req,
	output logic      o_run_lamp,
	output logic      o_halt_lamp
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// two flops per contact; first stage read only by the second
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	wire  [4:0] async_in = {i_clear_req, i_halt_nc, i_halt_no,
	                        i_run_nc, i_run_no};

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else if (i_ce) begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	wire run_no_s   = sync2_q[0];
	wire run_nc_s   = sync2_q[1];
	wire halt_no_s  = sync2_q[2];
	wire halt_nc_s  = sync2_q[3];
	wire clear_s    = sync2_q[4];

	// ----------------------------------------
	// pushbutton latches
	// ----------------------------------------
	// set-reset: a bouncing contact only repeats the same set or reset
	rhp_latch_t run_button_latch_q;
	rhp_latch_t halt_button_latch_q;
	rhp_latch_t run_latch_d;
	rhp_latch_t halt_latch_d;

	// set wins only while its contact is made; nc restores release
	function automatic rhp_latch_t latch_next(
		input logic       no_made,
		input logic       nc_made,
		input rhp_latch_t cur
	);
		// both open (bounce, travel) holds the last state
		if (no_made) begin
			return RHP_CLOSED;
		end else if (nc_made) begin
			return RHP_OPEN;
		end
		return cur;
	endfunction

	assign run_latch_d = latch_next(run_no_s, run_nc_s,
		run_button_latch_q);
	assign halt_latch_d = latch_next(halt_no_s, halt_nc_s,
		halt_button_latch_q);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_button_latch_q  <= RHP_OPEN;
			halt_button_latch_q <= RHP_OPEN;
		end else if (i_ce) begin
			run_button_latch_q  <= run_latch_d;
			halt_button_latch_q <= halt_latch_d;
		end
	end

	wire run_switch_level = (run_button_latch_q == RHP_CLOSED);
	wire halt_req         = (halt_button_latch_q == RHP_CLOSED);

	// ----------------------------------------
	// run synchroniser stages
	// ----------------------------------------
	logic run_sync_stage_a_q;
	logic run_sync_stage_b_q;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_sync_stage_a_q <= LATCH_RST;
			run_sync_stage_b_q <= LATCH_RST;
		end else if (i_ce) begin
			if (i_t2_strobe) begin
				run_sync_stage_a_q <= run_switch_level;
			end
			if (i_t1_strobe) begin
				run_sync_stage_b_q <= run_sync_stage_a_q;
			end
		end
	end

	// stage b kills the gate: one pulse per press however long held
	wire gate_term = ~run_sync_stage_b_q;
	wire run_pulse = run_sync_stage_a_q & gate_term;

	// ----------------------------------------
	// run-state flip-flops
	// ----------------------------------------
	// strobes are cycle-wide pulses; the strobe generator gives one cycle, under STROBE_MIN_CYC
	logic run_state_early_q;
	logic run_state_late_q;
	wire  early_reset = clear_s | halt_req;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			run_state_early_q <= RUN_STATE_RST;
			run_state_late_q  <= RUN_STATE_RST;
		end else if (i_ce) begin
			// halt is direct, so it beats a coincident set
			if (early_reset) begin
				run_state_early_q <= 1'h0;
			end else if (i_t5_end_strobe && run_pulse) begin
				run_state_early_q <= 1'h1;
			end
			if (i_phase_seven_s_strobe) begin
				if (!run_state_early_q) begin
					run_state_late_q <= 1'h0;
				end else if (run_pulse) begin
					run_state_late_q <= 1'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_run_pulse       = run_pulse;
	assign o_run_state_early = run_state_early_q;
	assign o_run_state_late  = run_state_late_q;
	assign o_halt_req        = halt_req;
	assign o_run_lamp        = run_state_late_q;
	assign o_halt_lamp       = ~run_state_late_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// strobes share the clock, so no synchroniser lag is allowed for here
	pulse_needs_a_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		$rose(o_run_pulse) |-> $past(i_t2_strobe) && $past(i_ce))
		else $error("run pulse rose off phase two");
	stage_b_kills_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_ce && i_t1_strobe && run_sync_stage_a_q) |=> !o_run_pulse)
		else $error("run pulse outlived phase one");
	a_follows_t2_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_ce && i_t2_strobe) |=>
			run_sync_stage_a_q == $past(run_switch_level))
		else $error("stage a missed phase two");
	a_holds_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		!(i_ce && i_t2_strobe) |=> $stable(run_sync_stage_a_q))
		else $error("stage a moved off phase two");
	b_follows_t1_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_ce && i_t1_strobe) |=>
			run_sync_stage_b_q == $past(run_sync_stage_a_q))
		else $error("stage b missed phase one");
	halt_clears_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_ce && halt_req) |=> !run_state_early_q)
		else $error("halt did not clear early state");
	clear_clears_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(i_ce && clear_s) |=> !run_state_early_q)
		else $error("clear did not clear early state");
	early_rise_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		$rose(run_state_early_q) |->
			$past(i_t5_end_strobe) && $past(run_pulse))
		else $error("early state set without strobe and pulse");
	late_rise_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		$rose(run_state_late_q) |->
			$past(i_phase_seven_s_strobe) && $past(run_pulse))
		else $error("late state set without strobe and pulse");
	late_fall_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(run_state_late_q) |->
			$past(i_phase_seven_s_strobe) && !$past(run_state_early_q))
		else $error("late state cleared off seven-s");
	pulse_once_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		$rose(o_run_pulse) |-> !$past(run_sync_stage_a_q))
		else $error("second run pulse without a new press");
	lamp_pair_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rstn)
		(o_run_lamp == run_state_late_q) && (o_halt_lamp != o_run_lamp))
		else $error("lamps disagree with late state");

endmodule

// ==== sim/rhp_panel_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// panel contacts and phase strobes
// ----------------------------------------
module rhp_panel_model (
	// clock and operator actions
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	input  wire logic i_run_press,
	input  wire logic i_halt_press,
	input  wire logic i_bounce,
	// contacts and strobes
	output logic      o_run_no,
	output logic      o_run_nc,
	output logic      o_halt_no,
	output logic      o_halt_nc,
	output logic      o_t1,
	output logic      o_t2,
	output logic      o_t5,
	output logic      o_t7s
);
	logic [5:0] ph_q;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ph_q <= 6'h00;
		end else begin
			ph_q <= ph_q + 6'h01;
		end
	end
	// one strobe each per 64-clock machine cycle, in phase order
	assign o_t1 = i_rstn && ph_q == 6'h00;
	assign o_t2 = i_rstn && ph_q == 6'h08;
	assign o_t5 = i_rstn && ph_q == 6'h28;
	assign o_t7s = i_rstn && ph_q == 6'h38;
	// bounce opens both run contacts, so the latch must hold its level
	assign o_run_no = i_run_press && !i_bounce;
	assign o_run_nc = !i_run_press && !i_bounce;
	assign o_halt_no = i_halt_press;
	assign o_halt_nc = !i_halt_press;
endmodule

// ==== sim/run_halt_panel_control_tb_top.sv ====
`timescale 1ns/1ps
module run_halt_panel_control_tb_top;
	import rhp_pkg::*;
	// set before time zero so no false falling edge starts the run
	logic clk = 1'h0;
	logic rstn, run_p, halt_p, bnc, clr, ce;
	logic rno, rnc, hno, hnc, t1, t2, t5, t7;
	logic pulse, early, late, hreq, rlamp, hlamp;
	int   errors, tests_run, pulses, width, last_w;
	rhp_panel_model panel (.i_ref_clk(clk), .i_rstn(rstn), .i_run_press(run_p),
		.i_halt_press(halt_p), .i_bounce(bnc), .o_run_no(rno), .o_run_nc(rnc),
		.o_halt_no(hno), .o_halt_nc(hnc), .o_t1(t1), .o_t2(t2), .o_t5(t5),
		.o_t7s(t7));
	rhp_run_halt dut (.i_ref_clk(clk), .i_rstn(rstn), .i_ce(ce),
		.i_run_no(rno), .i_run_nc(rnc), .i_halt_no(hno), .i_halt_nc(hnc),
		.i_clear_req(clr), .i_t1_strobe(t1), .i_t2_strobe(t2),
		.i_t5_end_strobe(t5), .i_phase_seven_s_strobe(t7),
		.o_run_pulse(pulse), .o_run_state_early(early),
		.o_run_state_late(late), .o_halt_req(hreq), .o_run_lamp(rlamp),
		.o_halt_lamp(hlamp));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// sampled on the falling edge, clear of the launching edge
	always @(negedge clk) begin
		if (pulse === 1'h1) begin
			pulses += (width == 0);
			width++;
		end else if (width != 0) begin
			last_w = width;
			width = 0;
		end
	end
	function automatic logic [7:0] lamps(input logic st);
		return {6'h00, st, !st};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %0h not %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic to_t1();
		int i;
		for (i = 0; i < 70 && t1 !== 1'h1; i++) begin
			@(negedge clk);
		end
		if (i == 70) begin
			errors++;
			stop_test();
		end
	endtask
	initial begin
		int k;
		int n;
		{rstn, run_p, halt_p, bnc, clr} = 5'h00;
		ce = 1'h1;
		{errors, tests_run, pulses, width, last_w} = '0;
		void'($urandom(32'hA1B7EEA0));
		repeat (2) @(negedge clk);
		rstn = 1'h1;
		// one edge out of reset passes before any contact moves
		@(negedge clk);
		check({pulse, early, late, hreq}, 8'h00);
		check({rlamp, hlamp}, lamps(1'h0));
		for (k = 0; k < 4; k++) begin
			n = $urandom_range(64, 320);
			run_p = 1'h1;
			repeat (n) begin
				@(negedge clk);
				bnc = ($urandom_range(0, 3) == 0);
			end
			{run_p, bnc} = 2'h0;
			repeat (192) @(negedge clk);
			check(8'(pulses), 8'(k + 1));
			check(8'(last_w), 8'(RUN_PULSE_CYC));
			check({early, late}, 8'h03);
			check({rlamp, hlamp}, lamps(1'h1));
			to_t1();
			// enable low: the request must wait and the states hold
			ce = 1'h0;
			if (k[0]) begin
				clr = 1'h1;
			end else begin
				halt_p = 1'h1;
			end
			repeat (8) @(negedge clk);
			check({hreq, early, late}, 8'h03);
			ce = 1'h1;
			// halt and clear take turns; late state trails to seven-s
			repeat (8) @(negedge clk);
			check({hreq, early, late}, {5'h00, !k[0], 2'h1});
			repeat (64) @(negedge clk);
			{halt_p, clr} = 2'h0;
			repeat (8) @(negedge clk);
			check({hreq, early, late}, 8'h00);
			check({rlamp, hlamp}, lamps(1'h0));
		end
		// reset in mid-run, with the pulse standing and early state set
		to_t1();
		run_p = 1'h1;
		repeat (48) @(negedge clk);
		check({pulse, early, late}, 8'h06);
		{rstn, run_p} = 2'h0;
		repeat (2) @(negedge clk);
		check({pulse, early, late, hreq}, 8'h00);
		check({rlamp, hlamp}, lamps(1'h0));
		rstn = 1'h1;
		repeat (2) @(negedge clk);
		check({pulse, early, late, hreq}, 8'h00);
		stop_test();
	end
endmodule
